// ===== inc/rtc_pkg.sv
// package: register map, field layout, timing and state types of the time-of-week counter
package rtc_pkg;

  // timing
  localparam int unsigned CLK_HZ        = 100_000_000;  // system clock rate
  localparam int unsigned SUB_HZ        = 32_768;       // subclock rate
  localparam int unsigned QUARTER_MS    = 250;          // shortest periodic interval
  localparam int unsigned BUSY_US       = 62_500;       // update delay after busy rises
  localparam int unsigned SUB_CYC_DEF   = CLK_HZ / SUB_HZ;                      // rounds down
  localparam int unsigned QUARTER_DEF   = QUARTER_MS * SUB_HZ / 1_000;          // subticks
  localparam int unsigned BUSY_DEF      = (BUSY_US / 125) * SUB_HZ / 8_000;    // subticks

  // widths of the prescaler counters and of the flag registers
  localparam int unsigned SUB_W  = 12;
  localparam int unsigned QTR_W  = 14;  // must hold the full quarter count of 8192
  localparam int unsigned BUSY_W = 12;
  localparam int unsigned FLG_W  = 7;

  // register byte addresses
  localparam logic [7:0] ADR_SEC    = 8'h00;  // seconds_count_reg / free counter
  localparam logic [7:0] ADR_MIN    = 8'h04;  // minutes_count_reg
  localparam logic [7:0] ADR_HR     = 8'h08;  // hours_count_reg
  localparam logic [7:0] ADR_WDAY   = 8'h0C;  // weekday_count_reg
  localparam logic [7:0] ADR_CTL1   = 8'h10;  // clock_control_first
  localparam logic [7:0] ADR_IRQEN  = 8'h14;  // periodic_irq_enable_reg
  localparam logic [7:0] ADR_CSSEL  = 8'h18;  // clock_source_select_reg
  localparam logic [7:0] ADR_FLAG   = 8'h1C;  // periodic_irq_flag_reg
  localparam logic [7:0] ADR_FLGCLR = 8'h20;  // write-one-to-clear alias of the flags
  localparam logic [7:0] ADR_SYSEN  = 8'h24;  // system_irq_enable_reg

  // clock_control_first fields
  localparam int unsigned CTL_RUN   = 7;  // counting runs
  localparam int unsigned CTL_HR24  = 6;  // 1: 00-23, 0: 00-11
  localparam int unsigned CTL_INTE  = 5;  // 1: flags at end of busy, 0: at its start
  localparam int unsigned CTL_CLR   = 4;  // write 1: reset the clock counters
  localparam int unsigned BUSY_BIT  = 7;  // update_in_progress in each time register

  // flag / enable bit positions
  localparam int unsigned EV_Q025 = 0;
  localparam int unsigned EV_Q05  = 1;
  localparam int unsigned EV_SEC  = 2;
  localparam int unsigned EV_MIN  = 3;
  localparam int unsigned EV_HR   = 4;
  localparam int unsigned EV_DAY  = 5;
  localparam int unsigned EV_WEEK = 6;

  // constants of the count ranges
  localparam logic [6:0] BCD_59    = 7'h59;
  localparam logic [6:0] BCD_23    = 7'h23;
  localparam logic [6:0] BCD_11    = 7'h11;
  localparam logic [3:0] BCD_NINE  = 4'h9;
  localparam logic [2:0] WDAY_LAST = 3'h6;
  localparam logic [2:0] CS_SUBCLK = 3'h0;  // subclock selected: time counting
  localparam logic [1:0] QIDX_LAST = 2'h3;

  // complete state of the block
  typedef struct packed {
    logic [SUB_W-1:0]  subCnt;    // clk cycles within one subclock period
    logic [QTR_W-1:0]  qCnt;      // subticks within a quarter second
    logic [1:0]        qIdx;      // quarter within the second
    logic              busy;      // update in progress
    logic [BUSY_W-1:0] busyCnt;   // subticks since busy rose
    logic [6:0]        sec;       // bcd seconds
    logic [6:0]        min;       // bcd minutes
    logic [5:0]        hr;        // bcd hours
    logic [2:0]        wday;      // binary day of week
    logic [7:0]        frc;       // free-running counter
    logic              run;
    logic              hr24;
    logic              intEnd;
    logic [2:0]        csSel;
    logic [FLG_W-1:0]  irqEn;
    logic [FLG_W-1:0]  flags;
    logic              sysIrqEn;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } rtc_state_t;

  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage : rtc_pkg

// ===== logic/bcd_time_of_week_counter.sv
// time-of-week counter with periodic interrupts and free-running mode, apb slave
//
// Decided for this implementation: the register offsets and the APB slave port.
module bcd_time_of_week_counter
  import rtc_pkg::*;
#(
  parameter logic [SUB_W-1:0]  SUB_CYC  = SUB_W'(SUB_CYC_DEF),  // clk cycles per subtick
  parameter logic [QTR_W-1:0]  QUARTER  = QTR_W'(QUARTER_DEF),  // subticks per quarter
  parameter logic [BUSY_W-1:0] BUSY_SUB = BUSY_W'(BUSY_DEF)     // subticks of busy
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // interrupt
  output logic             irq
);

  localparam rtc_state_t RESET_ST = '0;  // every field zero, counting stopped

  rtc_state_t st;        // registered state
  rtc_state_t nxt_st;    // next state
  apb_req_t   req;       // bundled request
  logic       subTick;   // one subclock period elapsed
  logic       timeMode;  // subclock selected
  logic       wrDone;    // write completes this edge
  logic       updEv;     // time registers change this edge
  logic [7:0] secStep;   // {carry, next seconds}
  logic [7:0] minStep;   // {carry, next minutes}
  logic [7:0] hrStep;    // {carry, next hours}
  logic       dayCarry;  // weekday wraps
  logic [FLG_W-1:0] carryEv;  // events of the coming update
  logic [FLG_W-1:0] ev;       // events this cycle
  logic [FLG_W-1:0] clr;      // flags cleared by software

  // one bcd step with wrap at top; top value gives zero and carry
  function automatic logic [7:0] bcdStep(input logic [6:0] v, input logic [6:0] top);
    logic [7:0] r;
    r = '0;
    if (v == top)
      r = {1'b1, 7'h00};
    else if (v[3:0] == BCD_NINE)
      r = {1'b0, 3'(v[6:4] + 3'h1), 4'h0};
    else
      r = {1'b0, v[6:4], 4'(v[3:0] + 4'h1)};
    return r;
  endfunction : bcdStep

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // carries of the next one-second update, from present values
  always_comb
  begin
    secStep  = bcdStep(st.sec, BCD_59);
    minStep  = bcdStep(st.min, BCD_59);
    hrStep   = bcdStep({1'b0, st.hr}, st.hr24 ? BCD_23 : BCD_11);
    dayCarry = (st.wday == WDAY_LAST);
    carryEv  = '0;
    carryEv[EV_SEC]  = 1'b1;
    carryEv[EV_MIN]  = secStep[7];
    carryEv[EV_HR]   = secStep[7] & minStep[7];
    carryEv[EV_DAY]  = secStep[7] & minStep[7] & hrStep[7];
    carryEv[EV_WEEK] = secStep[7] & minStep[7] & hrStep[7] & dayCarry;
  end

  // all next-state logic: prescaler, counting, flags, registers
  always_comb
  begin
    nxt_st   = st;
    ev       = '0;
    clr      = '0;
    updEv    = 1'b0;
    timeMode = (st.csSel == CS_SUBCLK);
    wrDone   = req.psel & req.penable & req.pwrite & st.pready;
    // subclock prescaler runs always; nothing here depends on the cpu clock state
    subTick       = (st.subCnt == SUB_CYC - SUB_W'(1));
    nxt_st.subCnt = subTick ? '0 : SUB_W'(st.subCnt + SUB_W'(1));

    if (timeMode)
    begin
      // time counting: quarter ticks, then busy window, then the update
      if (st.run && subTick)
      begin
        if (st.qCnt == QUARTER - QTR_W'(1))
        begin
          nxt_st.qCnt = '0;
          nxt_st.qIdx = 2'(st.qIdx + 2'h1);
          ev[EV_Q025] = 1'b1;
          ev[EV_Q05]  = st.qIdx[0];
          if (st.qIdx == QIDX_LAST)
          begin
            nxt_st.busy    = 1'b1;
            nxt_st.busyCnt = '0;
            if (!st.intEnd)
              ev = ev | carryEv;
          end
        end
        else
          nxt_st.qCnt = QTR_W'(st.qCnt + QTR_W'(1));
        if (st.busy)
        begin
          if (st.busyCnt == BUSY_SUB - BUSY_W'(1))
          begin
            // registers change only here, with busy falling in the same edge
            updEv       = 1'b1;
            nxt_st.busy = 1'b0;
            nxt_st.sec  = secStep[6:0];
            if (secStep[7])
              nxt_st.min = minStep[6:0];
            if (secStep[7] && minStep[7])
              nxt_st.hr = hrStep[5:0];
            if (carryEv[EV_DAY])
              nxt_st.wday = dayCarry ? 3'h0 : 3'(st.wday + 3'h1);
            if (st.intEnd)
              ev = ev | carryEv;
          end
          else
            nxt_st.busyCnt = BUSY_W'(st.busyCnt + BUSY_W'(1));
        end
      end
    end
    else if (st.run && subTick)
      nxt_st.frc = 8'(st.frc + 8'h01);

    // apb: one wait state, data latched in the first access cycle
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    if (req.psel && req.penable && !st.pready)
    begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = '0;
      unique case (req.paddr)
        ADR_SEC:    nxt_st.prdata[7:0] = timeMode ? {st.busy, st.sec} : st.frc;
        ADR_MIN:    nxt_st.prdata[7:0] = {st.busy, st.min};
        ADR_HR:     nxt_st.prdata[7:0] = {st.busy, 1'b0, st.hr};
        ADR_WDAY:   nxt_st.prdata[7:0] = {st.busy, 4'h0, st.wday};
        ADR_CTL1:   nxt_st.prdata[7:0] = {st.run, st.hr24, st.intEnd, 5'h00};
        ADR_IRQEN:  nxt_st.prdata[FLG_W-1:0] = st.irqEn;
        ADR_CSSEL:  nxt_st.prdata[2:0] = st.csSel;
        ADR_FLAG:   nxt_st.prdata[FLG_W-1:0] = st.flags;
        ADR_FLGCLR: nxt_st.prdata = '0;                         // write-only, reads zero
        ADR_SYSEN:  nxt_st.prdata[0] = st.sysIrqEn;
        default:    nxt_st.pslverr = 1'b1;                      // unmapped address
      endcase
    end

    // register writes take effect at the completing edge, over the counting
    if (wrDone)
    begin
      unique case (req.paddr)
        ADR_SEC:
        begin
          if (timeMode)
            nxt_st.sec = req.pwdata[6:0];
          else
            nxt_st.frc = req.pwdata[7:0];
        end
        ADR_MIN:    nxt_st.min = req.pwdata[6:0];
        ADR_HR:     nxt_st.hr = req.pwdata[5:0];
        ADR_WDAY:   nxt_st.wday = req.pwdata[2:0];
        ADR_CTL1:
        begin
          nxt_st.run    = req.pwdata[CTL_RUN];
          nxt_st.hr24   = req.pwdata[CTL_HR24];
          nxt_st.intEnd = req.pwdata[CTL_INTE];
          if (req.pwdata[CTL_CLR])
          begin
            // counter reset: time, free counter, quarter phase and busy restart; subCnt keeps running
            nxt_st.sec     = '0;
            nxt_st.min     = '0;
            nxt_st.hr      = '0;
            nxt_st.wday    = '0;
            nxt_st.frc     = '0;
            nxt_st.qCnt    = '0;
            nxt_st.qIdx    = '0;
            nxt_st.busy    = 1'b0;
            nxt_st.busyCnt = '0;
          end
        end
        ADR_IRQEN:  nxt_st.irqEn = req.pwdata[FLG_W-1:0];
        ADR_CSSEL:  nxt_st.csSel = req.pwdata[2:0];
        ADR_FLAG:   clr = ~req.pwdata[FLG_W-1:0];
        ADR_FLGCLR: clr = req.pwdata[FLG_W-1:0];
        ADR_SYSEN:  nxt_st.sysIrqEn = req.pwdata[0];
        default:    nxt_st.pslverr = 1'b0;                      // nothing stored
      endcase
    end

    // sticky flags: clear first so that a same-cycle event still sets
    nxt_st.flags = (st.flags & ~clr) | (ev & st.irqEn);
  end

  // single state register
  always_ff @(posedge clk)
  begin
    if (rst)
      st <= RESET_ST;
    else
      st <= nxt_st;
  end

  // outputs
  assign pready  = st.pready;
  assign prdata  = st.prdata;
  assign pslverr = st.pslverr;
  assign irq     = st.sysIrqEn & |(st.flags & st.irqEn);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // seconds wrap from 59 to 00
  a_sec_wrap: assert property (updEv && st.sec == BCD_59 && !wrDone |=> st.sec == 7'h00)
    else $error("seconds did not wrap to zero");

  // ones digit carries into the tens
  a_ones_carry: assert property (updEv && st.sec[3:0] == BCD_NINE && st.sec != BCD_59 && !wrDone
    |=> st.sec[3:0] == 4'h0 && st.sec[6:4] == $past(st.sec[6:4]) + 3'h1)
    else $error("ones digit did not carry into tens");

  // minutes move exactly on a seconds carry
  a_min_carry: assert property (updEv && !wrDone
    |=> (st.min != $past(st.min)) == ($past(st.sec) == BCD_59))
    else $error("minutes moved without seconds carry");

  // twelve-hour range wraps after 11
  a_hr_wrap: assert property (updEv && !wrDone && !st.hr24 && st.sec == BCD_59
    && st.min == BCD_59 && st.hr == 6'h11 |=> st.hr == 6'h00)
    else $error("hours did not wrap in twelve-hour range");

  // weekday wraps from 6 to 0 on the daily carry
  a_day_wrap: assert property (updEv && !wrDone && carryEv[EV_DAY] && st.wday == WDAY_LAST
    |=> st.wday == 3'h0)
    else $error("weekday did not wrap");

  // busy falls exactly when the time registers change
  // a counter-reset write also drops busy, so the write is looked at one cycle back
  a_busy_update: assert property (timeMode && !$past(wrDone) && $fell(st.busy)
    |-> $past(updEv))
    else $error("busy fell without an update");

  // flags hold until software clears them
  a_flag_sticky: assert property (st.flags[EV_SEC] && !wrDone |=> st.flags[EV_SEC])
    else $error("seconds flag dropped without a clear");

  // free counter frozen while stopped
  a_frc_stop: assert property (!timeMode && !st.run && !wrDone |=> $stable(st.frc))
    else $error("free counter moved while stopped");

  // free counter wraps from all ones
  a_frc_wrap: assert property (!timeMode && st.run && subTick && st.frc == 8'hFF && !wrDone
    |=> st.frc == 8'h00)
    else $error("free counter did not wrap");

  // interrupt follows the system enable
  a_irq_gate: assert property (!st.sysIrqEn |-> !irq)
    else $error("interrupt raised while system enable low");

  // seconds change on every update
  a_sec_step: assert property (updEv && !wrDone |=> st.sec != $past(st.sec))
    else $error("seconds did not step on update");

  // a ones digit below nine simply increments
  a_ones_step: assert property (updEv && !wrDone && st.sec[3:0] < BCD_NINE
    |=> st.sec[3:0] == $past(st.sec[3:0]) + 4'h1)
    else $error("ones digit did not increment");

  // time registers move only at the update edge or by a write
  a_time_hold: assert property (!updEv && !wrDone
    |=> $stable(st.sec) && $stable(st.min) && $stable(st.hr) && $stable(st.wday))
    else $error("time changed outside an update");

  // twenty-four-hour range wraps after 23
  a_hr24_wrap: assert property (updEv && !wrDone && st.hr24
    && st.sec == BCD_59 && st.min == BCD_59 && st.hr == 6'h23 |=> st.hr == 6'h00)
    else $error("hours did not wrap in twenty-four-hour range");

  // weekday below six steps by one on the daily carry
  a_day_step: assert property (updEv && !wrDone && carryEv[EV_DAY]
    && st.wday != WDAY_LAST |=> st.wday == $past(st.wday) + 3'h1)
    else $error("weekday did not step");

  // busy rises only on the last quarter tick of a second
  a_busy_start: assert property ($rose(st.busy)
    |-> $past(subTick) && $past(st.qIdx) == QIDX_LAST)
    else $error("busy rose off the second boundary");

  // busy stays up until the update edge
  a_busy_hold: assert property (st.busy && !updEv && !wrDone |=> st.busy)
    else $error("busy fell before the update");

  // an enabled event sets its flag, even against a same-cycle clear
  a_flag_set: assert property (ev[EV_SEC] && st.irqEn[EV_SEC]
    |=> st.flags[EV_SEC])
    else $error("enabled seconds event left its flag clear");

  // a disabled event never sets its flag
  a_flag_gate: assert property (!st.irqEn[EV_Q025] && !st.flags[EV_Q025]
    |=> !st.flags[EV_Q025])
    else $error("disabled quarter event set its flag");

  // flags come at busy rise or busy fall, as the timing bit selects
  a_int_timing: assert property (ev[EV_SEC]
    |-> (st.intEnd ? updEv : !st.busy))
    else $error("seconds event at the wrong end of busy");

  // the half-second event only comes with a quarter event
  a_half_quarter: assert property (ev[EV_Q05] |-> ev[EV_Q025])
    else $error("half-second event without quarter event");

  // free counter steps once per subtick while running
  a_frc_step: assert property (!timeMode && st.run && subTick && !wrDone
    |=> st.frc == $past(st.frc) + 8'h01)
    else $error("free counter did not step");

  // no periodic events while the free counter is selected
  a_free_quiet: assert property (!timeMode |-> ev == '0)
    else $error("periodic event in free-running mode");

  // prescaler never waits on anything, so sleep of the cpu cannot stall time
  a_sub_runs: assert property (st.subCnt != SUB_CYC - SUB_W'(1)
    |=> st.subCnt == $past(st.subCnt) + SUB_W'(1))
    else $error("subclock prescaler stalled");

  // interrupt rises only after a new event or a register write
  a_irq_cause: assert property ($rose(irq) |-> $past(wrDone) || $past(|ev))
    else $error("interrupt rose without event or write");

endmodule : bcd_time_of_week_counter

// ===== verification/tb_bcd_time_of_week_counter.sv
// testbench: apb-driven checks of the time-of-week counter
module tb_bcd_time_of_week_counter
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // clock and reset
  logic        clk;
  logic        rst;
  // apb master side
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  // interrupt
  logic        irq;
  // bookkeeping
  int          miscompares;
  int          checks;

  // short prescalers: one second is 128 clk cycles, busy lasts 12
  bcd_time_of_week_counter #(
    .SUB_CYC  (SUB_W'(4)),
    .QUARTER  (QTR_W'(8)),
    .BUSY_SUB (BUSY_W'(3))
  ) i_bcd_time_of_week_counter (
    .clk     (clk),
    .rst     (rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .irq     (irq)
  );

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) chk(32'h0000_0000, 32'h0000_0001, "no pready");
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask : rd

  // poll busy up then down; time must hold while busy is high
  task automatic wait_busy(input logic [7:0] s);
    logic [31:0] r;
    int          n;
    n = 0;
    do
    begin
      rd(ADR_SEC, r);
      n++;
    end
    while (r[BUSY_BIT] !== 1'b1 && n < 200);
    chk(r, {24'h0000_00, 1'b1, s[6:0]}, "busy with old time");
    n = 0;
    do
    begin
      rd(ADR_SEC, r);
      n++;
    end
    while (r[BUSY_BIT] !== 1'b0 && n < 200);
    if (n >= 200) chk(32'h0000_0000, 32'h0000_0001, "busy stuck");
  endtask : wait_busy

  // load a time, let one update pass, then compare time and flags
  task automatic run_update(input logic [7:0] s, m, h, w, input logic h24,
                            input logic [6:0] en, input logic [7:0] es, em, eh, ew,
                            input logic [6:0] ef);
    logic [31:0] r;
    wr(ADR_CTL1, 32'h0000_0010);
    wr(ADR_FLGCLR, 32'h0000_007F);
    wr(ADR_IRQEN, {25'h0, en});
    wr(ADR_SEC, {24'h0, s});
    wr(ADR_MIN, {24'h0, m});
    wr(ADR_HR, {24'h0, h});
    wr(ADR_WDAY, {24'h0, w});
    wr(ADR_CTL1, {24'h0, 1'b1, h24, 1'b1, 5'h00});
    wait_busy(s);
    wr(ADR_CTL1, {24'h0, 1'b0, h24, 1'b1, 5'h00});
    rd(ADR_SEC, r);
    chk(r, {24'h0, es}, "seconds");
    rd(ADR_MIN, r);
    chk(r, {24'h0, em}, "minutes");
    rd(ADR_HR, r);
    chk(r, {24'h0, eh}, "hours");
    rd(ADR_WDAY, r);
    chk(r, {24'h0, ew}, "weekday");
    rd(ADR_FLAG, r);
    chk(r, {25'h0, ef}, "flags");
  endtask : run_update

  // reset values and an unmapped address
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    apb(1'b0, ADR_CTL1, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0000, "control after reset");
    chk({31'h0, e}, 32'h0000_0000, "mapped read error");
    apb(1'b0, 8'h28, 32'h0000_0000, r, e);
    chk({e, r[30:0]}, 32'h8000_0000, "unmapped read");
    apb(1'b1, 8'h28, 32'hFFFF_FFFF, r, e);
    chk({31'h0, e}, 32'h0000_0001, "unmapped write");
    $display("test reset done");
  endtask : t_reset

  // full wrap in 24h mode, flags, system gate and clearing
  task automatic t_wrap24();
    logic [31:0] r;
    wr(ADR_SYSEN, 32'h0000_0001);
    run_update(8'h59, 8'h59, 8'h23, 8'h06, 1'b1, 7'h7C, 8'h00, 8'h00, 8'h00, 8'h00, 7'h7C);
    #1 chk({31'h0, irq}, 32'h0000_0001, "irq raised");
    wr(ADR_SYSEN, 32'h0000_0000);
    #1 chk({31'h0, irq}, 32'h0000_0000, "irq gated");
    wr(ADR_SYSEN, 32'h0000_0001);
    wr(ADR_FLAG, 32'h0000_007B);
    rd(ADR_FLAG, r);
    chk(r, 32'h0000_0078, "zero clears one flag");
    #1 chk({31'h0, irq}, 32'h0000_0001, "irq still up");
    wr(ADR_FLGCLR, 32'h0000_007F);
    rd(ADR_FLAG, r);
    chk(r, 32'h0000_0000, "flags cleared");
    #1 chk({31'h0, irq}, 32'h0000_0000, "irq dropped");
    $display("test wrap24 done");
  endtask : t_wrap24

  // 12h wrap carries a day; counter reset through control
  task automatic t_twelve();
    logic [31:0] r;
    run_update(8'h59, 8'h59, 8'h11, 8'h02, 1'b0, 7'h14, 8'h00, 8'h00, 8'h00, 8'h03, 7'h14);
    wr(ADR_CTL1, 32'h0000_0010);
    rd(ADR_WDAY, r);
    chk(r, 32'h0000_0000, "reset of counters");
    $display("test twelve done");
  endtask : t_twelve

  // ones digit carry, only the quarter flag enabled
  task automatic t_bcd();
    run_update(8'h09, 8'h00, 8'h05, 8'h01, 1'b1, 7'h01, 8'h10, 8'h00, 8'h05, 8'h01, 7'h01);
    $display("test bcd done");
  endtask : t_bcd

  // flags at busy rise: read after flag once busy is low, then twice and compare
  task automatic t_methods();
    logic [31:0] r;
    logic [31:0] a [4];
    int          n;
    wr(ADR_CTL1, 32'h0000_0010);
    wr(ADR_FLGCLR, 32'h0000_007F);
    wr(ADR_IRQEN, 32'h0000_0004);
    wr(ADR_SEC, 32'h0000_0030);
    wr(ADR_CTL1, 32'h0000_00C0);
    n = 0;
    do
    begin
      rd(ADR_FLAG, r);
      n++;
    end
    while (r[EV_SEC] !== 1'b1 && n < 200);
    rd(ADR_SEC, r);
    chk(r, 32'h0000_00B0, "flag at busy start");
    n = 0;
    do
    begin
      rd(ADR_SEC, r);
      n++;
    end
    while (r[BUSY_BIT] !== 1'b0 && n < 200);
    chk(r, 32'h0000_0031, "read after flag and busy low");
    for (int i = 0; i < 4; i++)
      rd(8'(4 * i), a[i]);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(4 * i), r);
      chk(r, a[i], "second reading matches");
    end
    chk(a[0], 32'h0000_0031, "first reading");
    rd(ADR_IRQEN, r);
    chk(r, 32'h0000_0004, "enable readback");
    rd(ADR_CTL1, r);
    chk(r, 32'h0000_00C0, "control readback");
    wr(ADR_CTL1, 32'h0000_0000);
    $display("test methods done");
  endtask : t_methods

  // free counter: wrap, stop by run, time frozen
  task automatic t_free();
    logic [31:0] r;
    logic [31:0] q;
    wr(ADR_CTL1, 32'h0000_0010);
    wr(ADR_CSSEL, 32'h0000_0001);
    wr(ADR_SEC, 32'h0000_00FE);
    rd(ADR_SEC, r);
    chk(r, 32'h0000_00FE, "free counter load");
    wr(ADR_CTL1, 32'h0000_0080);
    repeat (20) @(posedge clk);
    wr(ADR_CTL1, 32'h0000_0000);
    rd(ADR_SEC, r);
    // run held for 24 edges, one subtick per four clk whatever the phase
    chk(r, 32'h0000_0004, "wrap");
    repeat (40) @(posedge clk);
    rd(ADR_SEC, q);
    chk(q, r, "stopped counter holds");
    rd(ADR_MIN, r);
    chk(r, 32'h0000_0000, "time not counting");
    // run longer than one second of time mode: seconds must not move
    wr(ADR_CTL1, 32'h0000_0080);
    repeat (150) @(posedge clk);
    wr(ADR_CTL1, 32'h0000_0000);
    wr(ADR_CSSEL, 32'h0000_0000);
    rd(ADR_SEC, r);
    chk(r, 32'h0000_0000, "seconds held in free mode");
    $display("test free done");
  endtask : t_free

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // main sequence
  initial
  begin
    rst         = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    miscompares = 0;
    checks      = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_wrap24();
    t_twelve();
    t_bcd();
    t_methods();
    t_free();
    stop_test();
  end

  // watchdog: the whole sequence needs little more than a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

endmodule : tb_bcd_time_of_week_counter
